/* File: src/accel_config_status_regs.sv */
/*
  register slice: queue fill count, queue read port, health status and sampling configuration.
  assumes the host interface logic gives single-cycle read and write strobes on core_clk, and that
  the sensing core pushes samples and status levels from the same clock domain.
*/
`timescale 1ns/100ps
module accel_config_status_regs
  import accel_regs_pkg::*;
(
  // clock and reset
  input  wire logic             core_clk,
  input  wire logic             rst,
  // host register access
  input  wire logic             reg_wr,
  input  wire logic             reg_rd,
  input  wire logic [7:0]       reg_addr,
  input  wire logic [7:0]       reg_wdata,
  output logic      [7:0]       reg_rdata,
  output logic                  reg_rvalid,
  // sample bytes from the sensing core
  input  wire logic             push_valid,
  input  wire logic [7:0]       push_data,
  output logic                  push_ready,
  // status levels from the sensing core
  input  wire logic [2:0]       health_code,
  input  wire logic             axis_map_fault,
  input  wire logic             low_rate_feature_fault,
  input  wire logic             tap_rate_fault,
  input  wire logic [3:0]       motion_class,
  // configuration to the sensing core
  output sampling_type          sampling_cfg,
  output logic      [1:0]       range_cfg,
  output logic      [7:0]       avg_samples
);

  // two-entry skid buffer in front of the queue
  byte_beat_type skid_q [2];
  logic          skid_wr_q;
  logic          skid_rd_q;
  logic [1:0]    skid_cnt_q;
  logic [1:0]    skid_cnt_d;
  logic          skid_pop;
  logic          push_take;

  // queue storage
  logic [7:0]          mem [QUEUE_DEPTH];
  logic [QUEUE_AW-1:0] wr_ptr_q;
  logic [QUEUE_AW-1:0] rd_ptr_q;
  logic [COUNT_W-1:0]  fill_q;
  logic                q_full;
  logic                q_empty;
  logic                port_pop;

  sampling_type sampling_q;
  logic [1:0]   range_q;
  health_type   health_q;
  logic [7:0]   rdata_d;
  logic [7:0]   avg_d;

  assign q_full   = (fill_q == COUNT_W'(QUEUE_DEPTH));
  assign q_empty  = (fill_q == '0);
  assign skid_pop = (skid_cnt_q != 2'd0) && !q_full;
  assign port_pop = reg_rd && (reg_addr == ADDR_READ_PORT) && !q_empty;
  assign push_take = push_valid && push_ready;

  // skid occupancy after this edge
  always_comb begin
    skid_cnt_d = skid_cnt_q;
    if (push_take && !skid_pop) begin
      skid_cnt_d = skid_cnt_q + 2'd1;
    end else if (!push_take && skid_pop) begin
      skid_cnt_d = skid_cnt_q - 2'd1;
    end
  end

  // one storage slot per skid entry
  for (genvar e = 0; e < 2; e++) begin : g_skid
    always_ff @(posedge core_clk) begin
      if (rst) begin
        skid_q[e] <= '0;
      end else if (push_take && (skid_wr_q == 1'(e))) begin
        skid_q[e] <= '{valid: 1'b1, data: push_data};
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      skid_wr_q  <= 1'b0;
      skid_rd_q  <= 1'b0;
      skid_cnt_q <= 2'd0;
      push_ready <= 1'b0;
    end else begin
      if (push_take) begin
        skid_wr_q <= ~skid_wr_q;
      end
      if (skid_pop) begin
        skid_rd_q <= ~skid_rd_q;
      end
      skid_cnt_q <= skid_cnt_d;
      // second slot only offered while the queue can still drain it
      push_ready <= (skid_cnt_d == 2'd0) || ((skid_cnt_d == 2'd1) && !q_full);
    end
  end

  always_ff @(posedge core_clk) begin
    if (skid_pop) begin
      mem[wr_ptr_q] <= skid_q[skid_rd_q].data;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      fill_q   <= '0;
    end else begin
      if (skid_pop) begin
        wr_ptr_q <= wr_ptr_q + 1'b1;
      end
      if (port_pop) begin
        rd_ptr_q <= rd_ptr_q + 1'b1;
      end
      fill_q <= fill_q + COUNT_W'(skid_pop) - COUNT_W'(port_pop);
    end
  end

  // host writes; reserved bits are dropped
  always_ff @(posedge core_clk) begin
    if (rst) begin
      sampling_q <= sampling_type'(RST_SAMPLING);
      range_q    <= RST_FULL_SCALE[1:0];
    end else if (reg_wr) begin
      if (reg_addr == ADDR_SAMPLING) begin
        sampling_q <= sampling_type'(reg_wdata);
      end
      if (reg_addr == ADDR_FULL_SCALE) begin
        range_q <= reg_wdata[1:0];
      end
    end
  end

  // status capture
  always_ff @(posedge core_clk) begin
    if (rst) begin
      health_q <= health_type'(RST_ZERO);
    end else begin
      health_q.tap_rate_fault         <= tap_rate_fault;
      health_q.low_rate_feature_fault <= low_rate_feature_fault;
      health_q.axis_map_fault         <= axis_map_fault;
      health_q.state_code             <= {2'b00, health_code};
    end
  end

  // read mux
  always_comb begin
    rdata_d = RST_ZERO;
    case (reg_addr)
      ADDR_COUNT_LOW:  rdata_d = fill_q[7:0];
      ADDR_COUNT_HIGH: rdata_d = {2'b00, fill_q[13:8]};
      ADDR_READ_PORT:  rdata_d = q_empty ? RST_ZERO : mem[rd_ptr_q];
      ADDR_MOTION:     rdata_d = {4'h0, motion_class};
      ADDR_HEALTH:     rdata_d = health_q;
      ADDR_SAMPLING:   rdata_d = sampling_q;
      ADDR_FULL_SCALE: rdata_d = {6'h00, range_q};
      default:         rdata_d = RST_ZERO;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      reg_rdata  <= RST_ZERO;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        reg_rdata <= rdata_d;
      end
    end
  end

  // averaging count; reserved filter codes give zero
  always_comb begin
    avg_d = RST_ZERO;
    if (!sampling_q.cont_filter) begin
      avg_d = 8'(1) << sampling_q.bandwidth;
    end else if (sampling_q.bandwidth <= BW_CONT_MAX) begin
      avg_d = 8'(4) >> sampling_q.bandwidth;
    end
  end

  // configuration drives the sensing core; rate applies in every power mode
  always_ff @(posedge core_clk) begin
    if (rst) begin
      sampling_cfg <= sampling_type'(RST_SAMPLING);
      range_cfg    <= RST_FULL_SCALE[1:0];
      avg_samples  <= RST_ZERO;
    end else begin
      sampling_cfg <= sampling_q;
      range_cfg    <= range_q;
      avg_samples  <= avg_d;
    end
  end

endmodule

/* File: src/accel_regs_pkg.sv */
/*
  constants, types and register map of the accelerometer configuration and status register slice.
  assumes a single core clock domain and a host-side register access port that issues single-cycle strobes.
*/
// What this block does
// - the count-high register shows queue fill-level bits 13..8, resets to zero, and its two top bits read zero.
// - the count-low register shows the low eight bits of the queue fill level in bytes.
// - each read of the queue read port returns the next queued byte, supports bursts and resets to zero.
// - the status state code means 0 not initialised, 1 initialised, 2 init error, 3 invalid driver, 4 stopped.
// - bit 5 of the status register flags an invalid axis remapping.
// - bit 6 flags a bandwidth too low for features that use 50 Hz data.
// - bit 7 flags a bandwidth too low for single or double tap detection.
// - the status register is read-only, resets to zero and holds the three flags over the state code.
// - the rate field in bits 3:0 runs from code 1 at 25/32 Hz doubling to code 12 at 1600 Hz; 0 and 13..15 are reserved.
// - the selected output rate applies whatever the power mode.
// - bit 7 selects averaging when 0 and the continuous filter when 1.
// - in averaging, the bandwidth field in bits 6:4 averages 2 to the power of the code samples.
// - in continuous filtering, bandwidth codes 0, 1, 2 are 4x, 2x oversampling and normal; 3..7 are reserved.
// - the sampling setup register resets to 0xA8.
// - the range field in bits 1:0 picks 2g, 4g, 8g or 16g, resets to 1, and bits 7:2 are reserved.
package accel_regs_pkg;

  localparam logic [7:0] ADDR_COUNT_LOW   = 8'h24;
  localparam logic [7:0] ADDR_COUNT_HIGH  = 8'h25;
  localparam logic [7:0] ADDR_READ_PORT   = 8'h26;
  localparam logic [7:0] ADDR_MOTION      = 8'h27;
  localparam logic [7:0] ADDR_HEALTH      = 8'h2a;
  localparam logic [7:0] ADDR_SAMPLING    = 8'h40;
  localparam logic [7:0] ADDR_FULL_SCALE  = 8'h41;

  localparam logic [7:0] RST_SAMPLING     = 8'ha8;
  localparam logic [7:0] RST_FULL_SCALE   = 8'h01;
  localparam logic [7:0] RST_ZERO         = 8'h00;

  localparam logic [3:0] RATE_MIN         = 4'h1;
  localparam logic [3:0] RATE_MAX         = 4'hc;
  localparam logic [2:0] BW_CONT_MAX      = 3'h2;

  localparam int         COUNT_W          = 14;
  localparam int         QUEUE_DEPTH      = 1024;
  localparam int         QUEUE_AW         = 10;

  typedef enum logic [2:0] {
    HEALTH_NOT_INIT = 3'h0,
    HEALTH_INIT_OK  = 3'h1,
    HEALTH_INIT_ERR = 3'h2,
    HEALTH_DRV_ERR  = 3'h3,
    HEALTH_STOPPED  = 3'h4
  } health_code_type;

  typedef struct packed {
    logic tap_rate_fault;
    logic low_rate_feature_fault;
    logic axis_map_fault;
    logic [4:0] state_code;
  } health_type;

  typedef struct packed {
    logic       cont_filter;
    logic [2:0] bandwidth;
    logic [3:0] out_rate;
  } sampling_type;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } byte_beat_type;

endpackage

/* File: dv/accel_config_status_regs_monitor.sv */
/* port checker for the register slice.
   assumes it is bound onto the design top. */
`timescale 1ns/100ps
module accel_config_status_regs_monitor
  import accel_regs_pkg::*;
(
  // watched ports
  input wire logic         core_clk, rst, reg_wr, reg_rd, reg_rvalid,
  input wire logic [7:0]   reg_addr, reg_wdata, reg_rdata, avg_samples,
  input wire logic [1:0]   range_cfg,
  input wire sampling_type sampling_cfg
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  a_read_answer: assert property (reg_rd |=> reg_rvalid) else $error("no answer");
  a_no_stray: assert property (!reg_rd |=> !reg_rvalid && $stable(reg_rdata)) else $error("stray answer");
  a_count_rsvd: assert property (reg_rd && reg_addr == ADDR_COUNT_HIGH |=> reg_rdata[7:6] == 2'b00)
    else $error("count bits");
  a_health_rsvd: assert property (reg_rd && reg_addr == ADDR_HEALTH |=> reg_rdata[4:3] == 2'b00)
    else $error("health bits");
  a_range_rsvd: assert property (reg_rd && reg_addr == ADDR_FULL_SCALE |=> reg_rdata[7:2] == 6'h00)
    else $error("range bits");
  a_range_cfg: assert property (reg_wr && reg_addr == ADDR_FULL_SCALE |=> ##1 range_cfg == $past(reg_wdata[1:0], 2))
    else $error("range out");
  a_rate_cfg: assert property (reg_wr && reg_addr == ADDR_SAMPLING |=> ##1 sampling_cfg == $past(reg_wdata, 2))
    else $error("setup out");
  a_avg_count: assert property (!$past(rst) && !$past(rst, 2) && $stable(sampling_cfg) && !sampling_cfg.cont_filter
    |-> avg_samples == (8'h01 << sampling_cfg.bandwidth)) else $error("avg count");
  a_cont_count: assert property (!$past(rst) && !$past(rst, 2) && $stable(sampling_cfg) && sampling_cfg.cont_filter
    |-> avg_samples == ((sampling_cfg.bandwidth <= 3'h2) ? (8'h04 >> sampling_cfg.bandwidth) : 8'h00))
    else $error("filter count");
endmodule

bind accel_config_status_regs accel_config_status_regs_monitor i_mon(.core_clk(core_clk), .rst(rst),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rvalid(reg_rvalid), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_rdata(reg_rdata), .avg_samples(avg_samples), .range_cfg(range_cfg), .sampling_cfg(sampling_cfg));

/* File: dv/accel_host_model.sv */
/* host side model: single register reads and writes.
   assumes the strobe bus on core_clk, answer one cycle after a read. */
`timescale 1ns/100ps
module accel_host_model (
  // clock and answer
  input wire logic       core_clk, reg_rvalid,
  input wire logic [7:0] reg_rdata,
  // requests
  output logic           reg_wr, reg_rd,
  output logic [7:0]     reg_addr, reg_wdata
);
  initial {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
  task automatic wr(input logic [7:0] a, d);
    @(negedge core_clk) {reg_wr, reg_addr, reg_wdata} = {1'b1, a, d};
    @(negedge core_clk) {reg_wr, reg_addr, reg_wdata} = {1'b0, ~a, ~d};
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge core_clk) {reg_rd, reg_addr} = {1'b1, a};
    @(negedge core_clk) {reg_rd, reg_addr} = {1'b0, ~a};
    d = reg_rvalid ? reg_rdata : 8'hxx;
  endtask
endmodule

/* File: dv/accel_config_status_regs_tb.sv */
/* bench for the register slice: host model on the register side, bytes pushed from here.
   assumes the design, host model and checker are compiled first. */
`timescale 1ns/100ps
module accel_config_status_regs_tb
  import accel_regs_pkg::*;
;
  logic         core_clk = 0, rst = 1, reg_wr, reg_rd, reg_rvalid, push_valid = 0, push_ready;
  logic         axis_map_fault = 0, low_rate_feature_fault = 0, tap_rate_fault = 0;
  logic [7:0]   reg_addr, reg_wdata, reg_rdata, avg_samples, d, v, push_data = 0, q[$];
  logic [2:0]   health_code = 0;
  logic [3:0]   motion_class = 0;
  logic [1:0]   range_cfg;
  sampling_type sampling_cfg;
  logic [7:0]   ra[8] = '{8'h24, 8'h25, 8'h26, 8'h27, 8'h2a, 8'h40, 8'h41, 8'h30};
  logic [7:0]   rv[8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'ha8, 8'h01, 8'h00};
  int           n_fail = 0, n_compared = 0;
  accel_config_status_regs i_accel_config_status_regs(.core_clk(core_clk), .rst(rst), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .push_valid(push_valid), .push_data(push_data), .push_ready(push_ready), .health_code(health_code),
    .axis_map_fault(axis_map_fault), .low_rate_feature_fault(low_rate_feature_fault),
    .tap_rate_fault(tap_rate_fault), .motion_class(motion_class), .sampling_cfg(sampling_cfg),
    .range_cfg(range_cfg), .avg_samples(avg_samples));
  accel_host_model i_accel_host_model(.core_clk(core_clk), .reg_rvalid(reg_rvalid), .reg_rdata(reg_rdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata));
  initial forever #12.5 core_clk = ~core_clk;
  function automatic logic [7:0] exp_avg(input logic [7:0] s);
    if (!s[7]) return 8'h01 << s[6:4];
    return s[6:4] > 3'h2 ? 8'h00 : 8'h04 >> s[6:4];
  endfunction
  task automatic chk(input logic [7:0] got, exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic rchk(input logic [7:0] a, exp);
    i_accel_host_model.rd(a, d);
    chk(d, exp);
  endtask
  task automatic final_report;
    if (n_fail == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    v = $urandom(32'hfb55_546b);
    repeat (3) @(negedge core_clk);
    rst = 0;
    foreach (ra[i]) rchk(ra[i], rv[i]);
    chk(sampling_cfg, RST_SAMPLING);
    chk(avg_samples, 8'h01);
    motion_class = 4'($urandom);
    rchk(ADDR_MOTION, {4'h0, motion_class});
    for (int c = 0; c < 5; c++) begin
      {tap_rate_fault, low_rate_feature_fault, axis_map_fault} = 3'($urandom);
      health_code = 3'(c);
      i_accel_host_model.wr(ADDR_HEALTH, 8'hff);
      rchk(ADDR_HEALTH, {tap_rate_fault, low_rate_feature_fault, axis_map_fault, 2'b00, health_code});
    end
    for (int i = 0; i < 12; i++) begin
      v = {i[0], 3'($urandom), 4'(i + 1)};
      i_accel_host_model.wr(ADDR_SAMPLING, v);
      i_accel_host_model.wr(ADDR_FULL_SCALE, v);
      rchk(ADDR_SAMPLING, v);
      rchk(ADDR_FULL_SCALE, {6'h00, v[1:0]});
      chk(avg_samples, exp_avg(v));
      chk({6'h00, range_cfg}, {6'h00, v[1:0]});
    end
    repeat (1100) begin
      @(negedge core_clk);
      push_valid = 1;
      if (push_ready) begin
        q.push_back(push_data);
        @(posedge core_clk);
        push_data <= 8'($urandom);
      end
    end
    @(negedge core_clk);
    push_valid = 0;
    push_data = ~push_data;
    chk(8'(q.size() - 1024), 8'h02);
    rchk(ADDR_COUNT_LOW, 8'(q.size() - 2));
    rchk(ADDR_COUNT_HIGH, 8'((q.size() - 2) >> 8));
    while (q.size() > 0) rchk(ADDR_READ_PORT, q.pop_front());
    rchk(ADDR_READ_PORT, 8'h00);
    rchk(ADDR_COUNT_LOW, 8'h00);
    rst = 1;
    repeat (3) @(negedge core_clk);
    rst = 0;
    rchk(ADDR_SAMPLING, 8'ha8);
    final_report();
  end
endmodule
